// ### hw/gsacq_cfg.svh
`ifndef GSACQ_CFG_SVH
`define GSACQ_CFG_SVH
// Register numbers, used directly as the register port address
`define GSACQ_ADDR_W          16
`define GSACQ_OFS_MODE        16'h251C
`define GSACQ_OFS_TOTAL       16'h2710
`define GSACQ_OFS_GATE_LIMIT  16'h2724
`define GSACQ_OFS_PRE         16'h272E
`define GSACQ_OFS_POST        16'h2774
`define GSACQ_OFS_CMD         16'h2780
`define GSACQ_OFS_STATUS      16'h2784
`define GSACQ_OFS_GATE_COUNT  16'h2788
// Operating mode values
`define GSACQ_MODE_STD_GATE   32'h0000_0004
`define GSACQ_MODE_FIFO_GATE  32'h0000_0040
// Command and status bits
`define GSACQ_CMD_START_BIT   0
`define GSACQ_CMD_STOP_BIT    1
`define GSACQ_STS_RUN_BIT     0
`define GSACQ_STS_OVR_BIT     1
// Reset values
`define GSACQ_RST_MODE        32'h0000_0004
`define GSACQ_RST_TOTAL       64'h0000_0000_0000_0040
`define GSACQ_RST_PRE         64'h0000_0000_0000_0020
`define GSACQ_RST_POST        64'h0000_0000_0000_0020
// Sample path
`define GSACQ_SAMPLE_W        16
`define GSACQ_HIST_AW         14
`define GSACQ_FIFO_DEPTH      16
`endif

// ### hw/gsacq_core.sv
// Contract
// (RQ1) Store samples only while gate condition holds
// (RQ2) Pause after gate end until next gate
// (RQ3) Standard mode halts at total count, immediately
// (RQ4) Last standard segment ends by counter expiry
// (RQ5) Mode register: 4 standard, 64 streaming
// (RQ6) Total sample count register, read/write
// (RQ7) Streaming ignores total; ends by stop/gates
// (RQ8) Gate limit 0 endless, else gate count
// (RQ9) Streaming delivers data continuously to host
// (RQ10) Streaming transfers only in-gate samples
// (RQ11) Host programs counts in 32-sample steps
// (RQ12) Host keeps total>=64, pre 32..8k
// (RQ13) Max total limited only by memory
// (RQ14) Same minimum limits for all configurations
// (RQ15) Store pre-gate samples before each gate
// (RQ16) Store post-gate samples after each gate
// (RQ17) Gate counter stops streaming at limit
// (RQ18) Remaining counter decrements, stops at zero
`timescale 1ns/1ps
`include "gsacq_cfg.svh"
module gsacq_core
  import gsacq_pkg::*;
(
  // Clock and reset
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_b_in,
  // Register port
  input  wire logic [`GSACQ_ADDR_W-1:0]      reg_addr_in,
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  input  wire logic [63:0]                   reg_wdata_in,
  output logic      [63:0]                   reg_rdata_out,
  output logic                               reg_ack_out,
  // Acquisition front end
  input  wire logic                          gate_in,
  input  wire logic [`GSACQ_SAMPLE_W-1:0]    sample_in,
  // Sample stream to memory or host
  output logic      [`GSACQ_SAMPLE_W-1:0]    stream_data_out,
  output logic                               stream_valid_out,
  input  wire logic                          stream_ready_in,
  // Status
  output logic                               running_out
);
  localparam int HD = 1 << `GSACQ_HIST_AW;

  // Configuration registers
  logic [31:0] operating_mode_select;
  logic [63:0] total_sample_count;
  logic [63:0] gate_count_limit;
  logic [63:0] pre_gate_samples;
  logic [63:0] post_gate_samples;

  // Control and status
  gsacq_state_type                 state;
  logic                            overrun;
  logic [63:0]                     remain;
  logic [63:0]                     gate_cnt;
  logic [63:0]                     since_gate;
  logic                            win_q;
  logic                            win_qd;
  logic [`GSACQ_SAMPLE_W-1:0]      hist [HD];
  logic [`GSACQ_HIST_AW-1:0]       hist_wp;
  logic [`GSACQ_SAMPLE_W-1:0]      dly_sample;
  logic                            fifo_ready;
  logic                            push;
  logic                            seg_end;
  logic                            wr_mode;
  logic                            wr_total;
  logic                            wr_cmd;
  logic                            start_cmd;
  logic                            stop_cmd;
  logic                            std_mode;
  logic                            fifo_mode;
  logic                            std_done;
  logic                            gates_done;
  logic                            running;
  logic [63:0]                     next_rdata;

  // Register write decode
  assign wr_mode   = reg_wr_in && (reg_addr_in == `GSACQ_OFS_MODE);
  assign wr_total  = reg_wr_in && (reg_addr_in == `GSACQ_OFS_TOTAL);
  assign wr_cmd    = reg_wr_in && (reg_addr_in == `GSACQ_OFS_CMD);
  assign start_cmd = wr_cmd && reg_wdata_in[`GSACQ_CMD_START_BIT];
  assign stop_cmd  = wr_cmd && reg_wdata_in[`GSACQ_CMD_STOP_BIT];
  assign std_mode  = (operating_mode_select == `GSACQ_MODE_STD_GATE);  // [RQ5]
  assign fifo_mode = (operating_mode_select == `GSACQ_MODE_FIFO_GATE); // [RQ5]
  assign running   = (state == GSACQ_RUN);

  // Configuration storage; full 64-bit counts, no clamp in hardware
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      operating_mode_select <= `GSACQ_RST_MODE;
      total_sample_count    <= `GSACQ_RST_TOTAL;
      gate_count_limit      <= '0;
      pre_gate_samples      <= `GSACQ_RST_PRE;
      post_gate_samples     <= `GSACQ_RST_POST;
    end else if (reg_wr_in && !running) begin
      case (reg_addr_in)
        `GSACQ_OFS_MODE:       operating_mode_select <= reg_wdata_in[31:0]; // [RQ5]
        `GSACQ_OFS_TOTAL:      total_sample_count    <= reg_wdata_in;       // [RQ6] [RQ13] [RQ14]
        `GSACQ_OFS_GATE_LIMIT: gate_count_limit      <= reg_wdata_in;       // [RQ8]
        `GSACQ_OFS_PRE:        pre_gate_samples      <= reg_wdata_in;       // [RQ15]
        `GSACQ_OFS_POST:       post_gate_samples     <= reg_wdata_in;       // [RQ16]
        default: begin
        end
      endcase
    end
  end

  // Register read mux, unmapped addresses read zero
  always_comb begin
    next_rdata = '0;
    case (reg_addr_in)
      `GSACQ_OFS_MODE:       next_rdata = {32'h0000_0000, operating_mode_select};
      `GSACQ_OFS_TOTAL:      next_rdata = total_sample_count;
      `GSACQ_OFS_GATE_LIMIT: next_rdata = gate_count_limit;
      `GSACQ_OFS_PRE:        next_rdata = pre_gate_samples;
      `GSACQ_OFS_POST:       next_rdata = post_gate_samples;
      `GSACQ_OFS_STATUS:     next_rdata = {62'h0, overrun, running};
      `GSACQ_OFS_GATE_COUNT: next_rdata = gate_cnt;
      default:               next_rdata = '0;
    endcase
  end

  // Read data and acknowledge, one cycle after the strobe
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= '0;
      reg_ack_out   <= 1'b0;
    end else begin
      reg_ack_out <= reg_wr_in || reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= next_rdata;
      end
    end
  end

  // Cycles since gate was last seen true; saturates when idle long
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      since_gate <= '1;
    end else if (gate_in) begin
      since_gate <= '0;
    end else if (since_gate != '1) begin
      since_gate <= since_gate + 64'h1;
    end
  end

  // History ring delays samples by the pre-gate count
  always_ff @(posedge core_clk_in) begin
    hist[hist_wp] <= sample_in;
    dly_sample    <= hist[hist_wp - pre_gate_samples[`GSACQ_HIST_AW-1:0]]; // [RQ15]
  end

  // Ring write pointer
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hist_wp <= '0;
    end else begin
      hist_wp <= hist_wp + 1'b1;
    end
  end

  // Delayed sample is inside its window if gate was true within pre+post cycles
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      win_q  <= 1'b0;
      win_qd <= 1'b0;
    end else begin
      win_q  <= (since_gate <= pre_gate_samples + post_gate_samples); // [RQ1] [RQ15] [RQ16]
      win_qd <= win_q;
    end
  end

  // Store only inside the window while running, remaining count permitting
  assign push       = running && win_q && (!std_mode || remain != '0);         // [RQ1] [RQ10]
  assign seg_end    = running && win_qd && !win_q;                              // [RQ2]
  assign std_done   = std_mode && push && fifo_ready && (remain == 64'h1);      // [RQ3] [RQ4]
  assign gates_done = fifo_mode && seg_end && (gate_count_limit != '0)
                      && (gate_cnt + 64'h1 == gate_count_limit);                // [RQ17] [RQ8]

  // Run state: start on command, stop by command, count or gates
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= GSACQ_IDLE;
    end else begin
      case (state)
        GSACQ_IDLE: begin
          if (start_cmd && (std_mode || fifo_mode)) begin
            state <= GSACQ_RUN;
          end
        end
        GSACQ_RUN: begin
          if (stop_cmd || std_done || gates_done) begin // [RQ3] [RQ7] [RQ8]
            state <= GSACQ_IDLE;
          end
        end
        default: state <= GSACQ_IDLE;
      endcase
    end
  end

  // Remaining samples, loaded on start, counted down per stored sample in standard mode
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      remain <= '0;
    end else if (!running && start_cmd) begin
      remain <= total_sample_count; // [RQ6]
    end else if (std_mode && push && fifo_ready) begin
      remain <= remain - 64'h1;     // [RQ18]
    end
  end

  // Completed gate segments
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gate_cnt <= '0;
    end else if (!running && start_cmd) begin
      gate_cnt <= '0;
    end else if (seg_end) begin
      gate_cnt <= gate_cnt + 64'h1; // [RQ17]
    end
  end

  // Sticky overrun when the stream cannot take a sample; set wins over start
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      overrun <= 1'b0;
    end else if (push && !fifo_ready) begin
      overrun <= 1'b1;
    end else if (!running && start_cmd) begin
      overrun <= 1'b0;
    end
  end

  assign running_out = running;

  // Output buffer decouples the sample rate from the consumer
  gsacq_fifo #(
    .WIDTH (`GSACQ_SAMPLE_W),
    .DEPTH (`GSACQ_FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .rst_b_in      (rst_b_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (dly_sample),
    .out_valid_out (stream_valid_out),
    .out_ready_in  (stream_ready_in),
    .out_data_out  (stream_data_out)
  ); // [RQ9]

  // Checks
  sequence seq_seg_close;
    running && win_qd && !win_q;
  endsequence

  sequence seq_last_sample;
    running && std_mode && push && fifo_ready && remain == 64'h1;
  endsequence

  sequence seq_run_start;
    !running && start_cmd;
  endsequence

  // Window and storage checks, window recomputed from the gate distance
  chk_store_running: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ1]
    push |-> running && ($past(since_gate) <= $past(pre_gate_samples) + $past(post_gate_samples)))
    else $error("sample stored outside window");
  chk_pause_gap: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ2]
    seq_seg_close |-> !push && ($past(since_gate) > $past(pre_gate_samples) + $past(post_gate_samples)))
    else $error("store after segment close");
  chk_window_tail: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ1] [RQ16]
    gate_in |-> ##2 win_q)
    else $error("gate did not open window");

  // Standard mode count checks
  chk_std_halt: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ3]
    seq_last_sample |=> !running ##1 !push)
    else $error("no halt at total");
  chk_last_by_count: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ4]
    seq_last_sample and win_q |=> !running)
    else $error("open gate not cut");
  chk_std_run_on: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ2]
    running && std_mode && !stop_cmd && !std_done |=> running)
    else $error("standard run ended at gate close");
  chk_remain_load: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ6]
    seq_run_start |=> remain == $past(total_sample_count))
    else $error("remaining count not loaded");
  chk_remain_count: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ18]
    std_mode && push && fifo_ready |=> remain == $past(remain) - 64'h1)
    else $error("remaining count wrong");
  chk_remain_zero: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ18]
    std_done |=> remain == 64'h0)
    else $error("remaining count not empty at halt");

  // Run control checks
  chk_fifo_no_total: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ7]
    running && fifo_mode && !stop_cmd && !gates_done |=> running)
    else $error("streaming stopped early");
  chk_stop_cmd: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ7]
    running && stop_cmd |=> !running)
    else $error("software stop ignored");
  chk_gate_limit: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ17]
    seq_seg_close ##0 (fifo_mode && gate_count_limit != '0 && gate_cnt + 64'h1 == gate_count_limit)
    |=> !running && gate_cnt == $past(gate_count_limit)) else $error("gate limit missed");
  chk_gate_count_step: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ17]
    seq_seg_close |=> gate_cnt == $past(gate_cnt) + 64'h1)
    else $error("gate count not advanced");
  chk_endless: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ8]
    running && fifo_mode && gate_count_limit == '0 && !stop_cmd |=> running)
    else $error("endless run stopped");

  // Register port checks
  chk_mode_write: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ5]
    wr_mode && !running |=> operating_mode_select == $past(reg_wdata_in[31:0]))
    else $error("mode not written");
  chk_total_write: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ6]
    wr_total && !running |=> total_sample_count == $past(reg_wdata_in))
    else $error("total not written");
  chk_cfg_locked: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ6]
    running && reg_wr_in |=> $stable(operating_mode_select) && $stable(total_sample_count) && $stable(gate_count_limit))
    else $error("setting changed while running");
  chk_ack_follows: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ5]
    reg_wr_in || reg_rd_in |=> reg_ack_out)
    else $error("register access not acknowledged");
  chk_read_mode: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ5]
    reg_rd_in && reg_addr_in == `GSACQ_OFS_MODE |=> reg_rdata_out == {32'h0000_0000, $past(operating_mode_select)})
    else $error("mode read back wrong");
  chk_read_total: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ6]
    reg_rd_in && reg_addr_in == `GSACQ_OFS_TOTAL |=> reg_rdata_out == $past(total_sample_count))
    else $error("total read back wrong");
  chk_read_limit: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ8]
    reg_rd_in && reg_addr_in == `GSACQ_OFS_GATE_LIMIT |=> reg_rdata_out == $past(gate_count_limit))
    else $error("gate limit read back wrong");
  chk_status_read: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ9]
    reg_rd_in && reg_addr_in == `GSACQ_OFS_STATUS |=> reg_rdata_out[1:0] == {$past(overrun), $past(running)})
    else $error("status read back wrong");

  // Stream checks
  chk_stream_out: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ9]
    push && fifo_ready |=> stream_valid_out)
    else $error("stored sample not offered");
  chk_overrun_set: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ9]
    push && !fifo_ready |=> overrun)
    else $error("dropped sample not flagged");
  chk_overrun_hold: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [RQ9]
    overrun && !start_cmd |=> overrun)
    else $error("overrun flag not sticky");
endmodule // gsacq_core

// ### hw/gsacq_fifo.sv
`timescale 1ns/1ps
module gsacq_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             rst_b_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  // Handshakes and honest full/empty
  assign in_ready_out  = (fill < (AW+1)'(DEPTH));
  assign out_valid_out = (fill != '0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem[rd_ptr];

  // Storage array
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        fill <= fill + 1'b1;
      end else if (pop && !push) begin
        fill <= fill - 1'b1;
      end
    end
  end
endmodule // gsacq_fifo

// ### hw/gsacq_pkg.sv
package gsacq_pkg;
  typedef enum logic {GSACQ_IDLE, GSACQ_RUN} gsacq_state_type;
endpackage

// ### test/gsacq_core_tb.sv
`timescale 1ns/1ps
`include "gsacq_cfg.svh"
module gsacq_core_tb;
  logic        core_clk_in, rst_b_in, reg_wr, reg_rd, gate, rdy, slow, ack, vld, run;
  logic [15:0] addr, smp, sdata, last_w;
  logic [63:0] wdata, rdata;
  logic [64:0] exp_q[$];
  logic [64:0] e;
  int          error_cnt, cmp_count, cycles, words, segs, la, lb;

  gsacq_core DUT (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_ack_out(ack), .gate_in(gate),
    .sample_in(smp), .stream_data_out(sdata), .stream_valid_out(vld), .stream_ready_in(rdy), .running_out(run));
  gsacq_host_model host (.core_clk_in(core_clk_in), .slow_in(slow), .stream_ready_out(rdy));

  // Clock source
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = !core_clk_in;
  end

  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // One register cycle; a read notes its expected value for the monitor
  task automatic bus(input logic w, input logic [15:0] a, input logic [63:0] d, input logic chk);
    @(posedge core_clk_in);
    #1;
    addr = a; wdata = d; reg_wr = w; reg_rd = !w;
    exp_q.push_back({chk, d});
    @(posedge core_clk_in);
    #1;
    reg_wr = 1'b0; reg_rd = 1'b0;
  endtask

  task automatic gate_pulse(input int hi, input int lo);
    @(posedge core_clk_in);
    #1 gate = 1'b1;
    repeat (hi) @(posedge core_clk_in);
    #1 gate = 1'b0;
    repeat (lo) @(posedge core_clk_in);
  endtask

  // Sample counter as the input word, plus the hang limit
  always @(posedge core_clk_in) begin
    #1;
    smp = smp + 16'h1;
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end

  // Result watcher: register answers against notes, stream words into segments
  always @(posedge core_clk_in) begin
    if (ack === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[64]) check("register read", rdata, e[63:0]);
    end
    if (vld === 1'b1 && rdy === 1'b1) begin
      if (words == 0 || sdata !== last_w + 16'h1) segs++;
      last_w = sdata;
      words++;
    end
  end

  // Main sequence
  initial begin
    rst_b_in = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; gate = 1'b0; slow = 1'b0;
    addr = 16'h0; wdata = 64'h0; smp = 16'h0; words = 0; segs = 0;
    la = $urandom(32'hC22BCE58);
    repeat (20) @(posedge core_clk_in);
    #1 rst_b_in = 1'b1;
    repeat (40) @(posedge core_clk_in);
    bus(1'b0, `GSACQ_OFS_MODE, `GSACQ_RST_MODE, 1'b1);
    bus(1'b0, `GSACQ_OFS_TOTAL, `GSACQ_RST_TOTAL, 1'b1);
    bus(1'b0, `GSACQ_OFS_GATE_LIMIT, 64'h0, 1'b1);
    bus(1'b0, `GSACQ_OFS_PRE, `GSACQ_RST_PRE, 1'b1);
    bus(1'b0, `GSACQ_OFS_POST, `GSACQ_RST_POST, 1'b1);
    bus(1'b0, 16'h0000, 64'h0, 1'b1);
    // Standard run: short gate, then a long gate cut by the counter
    bus(1'b1, `GSACQ_OFS_TOTAL, 64'h60, 1'b0);
    bus(1'b0, `GSACQ_OFS_TOTAL, 64'h60, 1'b1);
    words = 0; segs = 0;
    bus(1'b1, `GSACQ_OFS_CMD, 64'h1, 1'b0);
    gate_pulse(20, 200);
    fork
      gate_pulse(200, 100);
      begin
        repeat (120) @(posedge core_clk_in);
        check("halt inside open gate", run, 64'h0);
      end
    join
    check("standard word count", words, 64'd96);
    check("standard segments", segs, 64'd2);
    // Streaming run limited to two gates
    bus(1'b1, `GSACQ_OFS_MODE, `GSACQ_MODE_FIFO_GATE, 1'b0);
    bus(1'b0, `GSACQ_OFS_MODE, `GSACQ_MODE_FIFO_GATE, 1'b1);
    bus(1'b1, `GSACQ_OFS_GATE_LIMIT, 64'h2, 1'b0);
    words = 0; segs = 0;
    la = 40 + $urandom % 60;
    lb = 40 + $urandom % 60;
    bus(1'b1, `GSACQ_OFS_CMD, 64'h1, 1'b0);
    gate_pulse(la, 200);
    gate_pulse(lb, 200);
    check("gated words only", words >= la + lb + 126 && words <= la + lb + 130, 64'h1);
    check("segments", segs, 64'd2);
    check("stop at gate limit", run, 64'h0);
    bus(1'b0, `GSACQ_OFS_GATE_COUNT, 64'h2, 1'b1);
    // Endless streaming until software stop
    bus(1'b1, `GSACQ_OFS_GATE_LIMIT, 64'h0, 1'b0);
    bus(1'b1, `GSACQ_OFS_CMD, 64'h1, 1'b0);
    repeat (3) gate_pulse(30, 150);
    check("endless keeps running", run, 64'h1);
    bus(1'b1, `GSACQ_OFS_CMD, 64'h2, 1'b0);
    repeat (5) @(posedge core_clk_in);
    check("software stop", run, 64'h0);
    // Slow host: FIFO overflows and the overrun flag sticks
    slow = 1'b1;
    bus(1'b1, `GSACQ_OFS_CMD, 64'h1, 1'b0);
    gate_pulse(60, 150);
    bus(1'b1, `GSACQ_OFS_CMD, 64'h2, 1'b0);
    slow = 1'b0;
    repeat (30) @(posedge core_clk_in);
    bus(1'b0, `GSACQ_OFS_STATUS, 64'h2, 1'b1);
    repeat (5) @(posedge core_clk_in);
    conclude();
  end
endmodule // gsacq_core_tb

// ### test/gsacq_host_model.sv
`timescale 1ns/1ps
module gsacq_host_model (
  // Clock
  input  wire logic core_clk_in,
  // Pace select from the bench
  input  wire logic slow_in,
  // Stream handshake back to the device
  output logic      stream_ready_out
);
  logic [1:0] pace;
  // Prompt host takes every word; slow host takes one word in four
  initial begin
    stream_ready_out = 1'b1;
    pace = 2'h0;
    forever begin
      @(posedge core_clk_in);
      #1;
      pace = pace + 2'h1;
      stream_ready_out = !slow_in || (pace == 2'h0);
    end
  end
endmodule // gsacq_host_model
